// ===== verilog/dma_burst_pkg.sv
// Constants, field layouts and types for the timer DMA burst window unit
package dma_burst_pkg;

   // ==========================================================
   // Register map
   localparam logic [7:0] OFF_TIMER_BASE = 8'h00;
   localparam logic [7:0] OFF_CONTROL = 8'h48;
   localparam logic [7:0] OFF_WINDOW = 8'h4C;

   // ==========================================================
   // Control register fields
   localparam int unsigned LEN_LSB = 8;
   localparam int unsigned LEN_MSB = 12;
   localparam int unsigned BASE_LSB = 0;
   localparam int unsigned BASE_MSB = 4;
   localparam logic [15:0] CONTROL_RESET = 16'h0000;
   localparam logic [15:0] WINDOW_RESET = 16'h0000;
   localparam logic [15:0] CONTROL_WMASK = 16'h1F1F;

   // ==========================================================
   // Slot codes
   localparam logic [5:0] SLOT_RSVD_A = 6'h0C;
   localparam logic [5:0] SLOT_RSVD_B = 6'h11;
   localparam logic [5:0] SLOT_CONTROL = 6'h12;
   localparam int unsigned SLOT_SHIFT = 2;

   // ==========================================================
   // Buffering
   localparam int unsigned FIFO_DEPTH = 4;

   // ==========================================================
   // Types
   typedef struct packed {
      logic [7:0] addr;
      logic [15:0] data;
   } slot_write_t;

   typedef struct packed {
      logic [4:0] len;
      logic [4:0] base;
   } burst_cfg_t;

   typedef enum logic [0:0] {
      SEQ_IDLE = 1'b0,
      SEQ_BURST = 1'b1
   } seq_state_t;

endpackage

// ===== verilog/burst_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module burst_fifo #(
   parameter int unsigned WIDTH = 24,
   parameter int unsigned DEPTH = 4
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int unsigned CNT_W = $clog2(DEPTH + 1);
   localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
   localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PTR_W-1:0] wr_ptr_reg;
   logic [PTR_W-1:0] rd_ptr_reg;
   logic [CNT_W-1:0] count_reg;
   logic push;
   logic pop;

   assign o_in_ready = (count_reg != CNT_FULL);
   assign o_out_valid = (count_reg != '0);
   assign o_out_data = mem_reg[rd_ptr_reg];
   assign push = i_in_valid & o_in_ready;
   assign pop = o_out_valid & i_out_ready;

   // Storage carries no reset; only occupied entries are ever read
   always_ff @(posedge i_clk_sys) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= i_in_data;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         count_reg <= '0;
      end else if (push && !pop) begin
         count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
         count_reg <= count_reg - 1'b1;
      end
   end
endmodule
`default_nettype wire

// ===== verilog/burst_sequencer.sv
// Burst index counter and burst state
`timescale 1ns/1ps
`default_nettype none
module burst_sequencer
   import dma_burst_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_event,
   input wire logic i_access,
   input wire logic [4:0] i_len,
   output logic [4:0] o_index,
   output logic o_busy,
   output logic o_last_access
);
   seq_state_t state_reg;
   logic [4:0] index_reg;
   logic at_last;

   // A length shrunk to or below the index mid-burst still ends the burst at the next window access
   assign at_last = (index_reg >= i_len);
   assign o_last_access = i_access & at_last;
   assign o_index = index_reg;
   assign o_busy = (state_reg == SEQ_BURST);

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         index_reg <= 5'h00;
      end else if (i_access) begin
         index_reg <= at_last ? 5'h00 : index_reg + 5'h01;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_reg <= SEQ_IDLE;
      end else begin
         unique case (state_reg)
            SEQ_IDLE: begin
               if (i_event && !i_access) begin
                  state_reg <= SEQ_BURST;
               end
            end
            SEQ_BURST: begin
               if (o_last_access) begin
                  state_reg <= SEQ_IDLE;
               end
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ===== verilog/timer_dma_burst_window.sv
// Timer DMA burst window: control register, window redirect and request logic
`timescale 1ns/1ps
`default_nettype none
module timer_dma_burst_window
   import dma_burst_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic [7:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [15:0] o_rdata,
   input wire logic i_event,
   output logic o_dma_req,
   output logic o_burst_busy,
   output logic o_slot_rd,
   output logic [7:0] o_slot_raddr,
   input wire logic [15:0] i_slot_rdata,
   output logic o_slot_wvalid,
   output logic [7:0] o_slot_waddr,
   output logic [15:0] o_slot_wdata,
   input wire logic i_slot_wready
);

   // ==========================================================
   // Declarations
   logic [15:0] control_reg;
   logic [15:0] control_next;
   logic [15:0] rdata_reg;
   logic [15:0] rdata_next;
   burst_cfg_t cfg;
   logic ctl_wr;
   logic ctl_rd;
   logic win_wr;
   logic win_rd;
   logic window_access;
   logic [4:0] index;
   logic busy;
   logic last_access;
   logic [5:0] slot_now;
   logic [7:0] slot_byte_addr;
   logic slot_timer;
   logic slot_ctl;
   slot_write_t fifo_in;
   slot_write_t fifo_out;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic drain_ctl;
   logic drain_ctl_take;

   // ==========================================================
   // Slot decode helpers
   function automatic logic is_timer_slot(input logic [5:0] slot);
      is_timer_slot = (slot < SLOT_CONTROL) && (slot != SLOT_RSVD_A) && (slot != SLOT_RSVD_B);
   endfunction

   function automatic logic [7:0] slot_to_addr(input logic [5:0] slot);
      logic [7:0] wide;
      wide = {slot, 2'b00};
      slot_to_addr = OFF_TIMER_BASE + wide;
   endfunction

   // ==========================================================
   // Bus decode
   assign ctl_wr = i_wr && (i_addr == OFF_CONTROL);
   assign ctl_rd = i_rd && (i_addr == OFF_CONTROL);
   assign win_wr = i_wr && (i_addr == OFF_WINDOW);
   assign win_rd = i_rd && (i_addr == OFF_WINDOW);
   assign window_access = win_wr | win_rd;

   assign cfg.len = control_reg[LEN_MSB:LEN_LSB];
   assign cfg.base = control_reg[BASE_MSB:BASE_LSB];

   // ==========================================================
   // Burst sequencing
   burst_sequencer u_seq (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_event(i_event),
      .i_access(window_access),
      .i_len(cfg.len),
      .o_index(index),
      .o_busy(busy),
      .o_last_access(last_access)
   );

   assign slot_now = {1'b0, cfg.base} + {1'b0, index};
   assign slot_byte_addr = slot_to_addr(slot_now);
   assign slot_timer = is_timer_slot(slot_now);
   assign slot_ctl = (slot_now == SLOT_CONTROL);

   // ==========================================================
   // Window write path through the FIFO
   // Writes to reserved slots are dropped here and never leave the block
   assign fifo_in_valid = win_wr && (slot_timer || slot_ctl);
   assign fifo_in.addr = slot_byte_addr;
   assign fifo_in.data = i_wdata;

   burst_fifo #(
      .WIDTH($bits(slot_write_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_in_valid(fifo_in_valid),
      .o_in_ready(fifo_in_ready),
      .i_in_data(fifo_in),
      .o_out_valid(fifo_out_valid),
      .i_out_ready(fifo_out_ready),
      .o_out_data(fifo_out)
   );

   // Window write lands in mapped register
   assign drain_ctl = (fifo_out.addr == OFF_CONTROL);
   assign fifo_out_ready = drain_ctl | i_slot_wready;
   assign drain_ctl_take = fifo_out_valid & drain_ctl;
   assign o_slot_wvalid = fifo_out_valid & ~drain_ctl;
   assign o_slot_waddr = fifo_out.addr;
   assign o_slot_wdata = fifo_out.data;

   // ==========================================================
   // Window read path
   // Address is combinational so the timer answers in the strobe cycle
   // Window read fetches mapped register
   assign o_slot_rd = win_rd & slot_timer;
   assign o_slot_raddr = slot_byte_addr;

   // ==========================================================
   // DMA request
   // Dropping the request while the FIFO is full throttles the DMA controller
   // Request while burst open
   assign o_dma_req = busy & fifo_in_ready;
   assign o_burst_busy = busy;

   // ==========================================================
   // Control register
   always_comb begin
      control_next = control_reg;
      if (ctl_wr) begin
         control_next = i_wdata & CONTROL_WMASK;
      end else if (drain_ctl_take) begin
         control_next = fifo_out.data & CONTROL_WMASK;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         control_reg <= CONTROL_RESET;
      end else begin
         control_reg <= control_next;
      end
   end

   // ==========================================================
   // Read data, valid only in the cycle after the strobe
   always_comb begin
      rdata_next = 16'h0000;
      if (ctl_rd) begin
         rdata_next = control_reg;
      end else if (win_rd) begin
         if (slot_timer) begin
            rdata_next = i_slot_rdata;
         end else if (slot_ctl) begin
            rdata_next = control_reg;
         end else begin
            rdata_next = WINDOW_RESET;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdata_reg <= 16'h0000;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign o_rdata = rdata_reg;

   // ==========================================================
   // Helper counting window accesses inside a burst
   logic [5:0] burst_cnt_reg;
   logic [4:0] len_at_start_reg;

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         burst_cnt_reg <= 6'h00;
         len_at_start_reg <= 5'h00;
      end else if (!busy) begin
         burst_cnt_reg <= 6'h00;
         len_at_start_reg <= cfg.len;
      end else if (window_access) begin
         burst_cnt_reg <= burst_cnt_reg + 6'h01;
      end
   end

   // ==========================================================
   // Checks
   // Burst ends after len plus one
   a_burst_length: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (busy && window_access && !ctl_wr && !drain_ctl_take && (burst_cnt_reg == {1'b0, cfg.len})
       && (cfg.len == len_at_start_reg))
      |=> !busy)
      else $error("burst did not end after length plus one accesses");

   a_burst_continues: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (busy && window_access && (index < cfg.len)) |=> busy)
      else $error("burst closed before its last access");

   a_ctrl_via_window: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (drain_ctl_take && !ctl_wr)
      |=> (control_reg == ($past(fifo_out.data) & CONTROL_WMASK)))
      else $error("window write to control slot not applied");

   a_slot_step: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (window_access && (index < cfg.len) && $stable(cfg.len))
      |=> (index == ($past(index) + 5'h01)))
      else $error("burst index did not step by one");

   a_first_slot: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      $rose(busy) |-> (index == 5'h00) || $past(window_access))
      else $error("burst did not open at the base slot");

   a_addr_bound: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      o_slot_rd |-> (o_slot_raddr >= slot_to_addr({1'b0, cfg.base}))
                 && (o_slot_raddr <= slot_to_addr({1'b0, cfg.base} + {1'b0, cfg.len})))
      else $error("window read outside burst address range");

   a_window_read: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      o_slot_rd |=> (o_rdata == $past(i_slot_rdata)))
      else $error("window read did not return mapped register");

   a_window_write: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (win_wr && slot_timer && !fifo_out_valid)
      |=> o_slot_wvalid && (o_slot_wdata == $past(i_wdata))
          && (o_slot_waddr == $past(slot_byte_addr)))
      else $error("window write not forwarded to mapped register");

   a_rdata_once: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      !i_rd |=> (o_rdata == 16'h0000))
      else $error("read data present without a read");

   a_event_request: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_event && !busy && !window_access) |=> busy ##0 (o_dma_req || !fifo_in_ready))
      else $error("enabled event did not raise a DMA request");

   a_request_gate: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      o_dma_req |-> busy && fifo_in_ready)
      else $error("DMA request outside a burst or with FIFO full");

   a_ctrl_reserved: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      ##1 ((control_reg & ~CONTROL_WMASK) == 16'h0000))
      else $error("reserved control bits not zero");

   a_index_reset: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      last_access |=> (index == 5'h00) && !busy)
      else $error("index not reset after last access");

   // ==========================================================
   // Further checks on register and slot paths
   // Direct control write masked
   a_ctrl_write: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      ctl_wr |=> (control_reg == ($past(i_wdata) & CONTROL_WMASK)))
      else $error("control write not stored with reserved bits cleared");

   a_ctrl_readback: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      ctl_rd |=> (o_rdata == $past(control_reg)))
      else $error("control read did not return control value");

   a_reserved_read: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (win_rd && !slot_timer && !slot_ctl) |=> (o_rdata == WINDOW_RESET))
      else $error("reserved slot read not zero");

   a_ctrl_slot_read: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (win_rd && slot_ctl) |=> (o_rdata == $past(control_reg)))
      else $error("window read of control slot wrong");

   // Read address from base and index
   a_raddr_map: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      o_slot_rd |-> (o_slot_raddr == (OFF_TIMER_BASE + (({3'b000, cfg.base} + {3'b000, index}) * 8'h04))))
      else $error("window read address not base plus index times four");

   a_wvalid_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (o_slot_wvalid && !i_slot_wready)
      |=> o_slot_wvalid && $stable(o_slot_waddr) && $stable(o_slot_wdata))
      else $error("pending timer write changed before acceptance");

   a_waddr_timer: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      o_slot_wvalid |-> (o_slot_waddr < slot_to_addr(SLOT_CONTROL)))
      else $error("timer write outside timer register range");

   a_burst_holds: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (busy && !window_access) |=> busy)
      else $error("burst closed without a window access");

   a_idle_no_req: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      !busy |-> !o_dma_req)
      else $error("DMA request while idle");

   a_open_on_event: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      $rose(busy) |-> $past(i_event))
      else $error("burst opened without an event");

   a_index_idle: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      $fell(busy) |-> (index == 5'h00))
      else $error("index not at base when burst closed");

   a_first_access: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (busy && window_access && (burst_cnt_reg == 6'h00)) |-> (index == 5'h00))
      else $error("first burst access not at base slot");

endmodule
`default_nettype wire

// ===== tb/dma_partner.sv
// Behavioural system DMA controller that moves words through the window
`timescale 1ns/1ps
`default_nettype none
module dma_partner
   import dma_burst_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_enable,
   input wire logic i_write,
   input wire logic i_slow,
   input wire logic i_dma_req,
   input wire logic [15:0] i_rdata,
   output logic [7:0] o_addr,
   output logic [15:0] o_wdata,
   output logic o_wr,
   output logic o_rd,
   output logic [5:0] o_count
);
   // ==========================================================
   // Captured read words, one per access
   logic [15:0] mem [0:31];
   logic rd_d1;
   logic [2:0] gap;

   // ==========================================================
   // Access engine
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_addr <= OFF_WINDOW;
         o_wdata <= 16'h0000;
         o_wr <= 1'b0;
         o_rd <= 1'b0;
         o_count <= 6'h00;
         rd_d1 <= 1'b0;
         gap <= 3'h0;
      end else begin
         o_wr <= 1'b0;
         o_rd <= 1'b0;
         rd_d1 <= o_rd;
         if (gap != 3'h0) begin
            gap <= gap - 3'h1;
         end
         // Read data stands only in the cycle after the strobe
         if (rd_d1) begin
            mem[o_count - 6'h01] <= i_rdata;
         end
         if (!i_enable) begin
            o_count <= 6'h00;
         // Fixed window address
         // Strobe cycle blocks reissue, as request lags the taking edge
         end else if (i_dma_req && !o_rd && !o_wr && gap == 3'h0) begin
            o_addr <= OFF_WINDOW;
            o_wdata <= 16'hD000 | {10'h000, o_count};
            o_wr <= i_write;
            o_rd <= !i_write;
            o_count <= o_count + 6'h01;
            gap <= i_slow ? 3'h5 : 3'h0;
         end
      end
   end
endmodule
`default_nettype wire

// ===== tb/timer_dma_burst_window_bench.sv
// Self-checking bench for the timer DMA burst window
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module timer_dma_burst_window_bench
   import dma_burst_pkg::*;
();
   // ==========================================================
   // Signals
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] b_addr = 8'h00;
   logic [15:0] b_wdata = 16'h0000;
   logic b_wr = 1'b0;
   logic b_rd = 1'b0;
   logic ev = 1'b0;
   logic wready = 1'b1;
   logic dma_en = 1'b0;
   logic dma_wr = 1'b0;
   logic slow = 1'b0;
   logic [7:0] p_addr, addr, slot_raddr, slot_waddr;
   logic [15:0] p_wdata, wdata, rdata, slot_rdata, slot_wdata;
   logic p_wr, p_rd, wr, rd, dma_req, busy, slot_rd, slot_wvalid;
   logic [5:0] p_count;
   logic [23:0] drained [$];
   int fail_count = 0;
   int checks = 0;

   always #5 clk = ~clk;
   // DMA owns the bus while enabled
   assign addr = dma_en ? p_addr : b_addr;
   assign wdata = dma_en ? p_wdata : b_wdata;
   assign wr = dma_en ? p_wr : b_wr;
   assign rd = dma_en ? p_rd : b_rd;
   // Timer registers answer with a tag of their own address
   assign slot_rdata = {8'h5A, slot_raddr};
   always @(posedge clk) begin
      if (slot_wvalid === 1'b1 && wready === 1'b1) begin
         drained.push_back({slot_waddr, slot_wdata});
      end
   end

   timer_dma_burst_window timer_dma_burst_window_i (
      .i_clk_sys(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_event(ev), .o_dma_req(dma_req),
      .o_burst_busy(busy), .o_slot_rd(slot_rd), .o_slot_raddr(slot_raddr),
      .i_slot_rdata(slot_rdata), .o_slot_wvalid(slot_wvalid),
      .o_slot_waddr(slot_waddr), .o_slot_wdata(slot_wdata), .i_slot_wready(wready));

   dma_partner dma_partner_i (
      .i_clk_sys(clk), .i_rst_n(rst_n), .i_enable(dma_en), .i_write(dma_wr),
      .i_slow(slow), .i_dma_req(dma_req), .i_rdata(rdata), .o_addr(p_addr),
      .o_wdata(p_wdata), .o_wr(p_wr), .o_rd(p_rd), .o_count(p_count));

   // ==========================================================
   // Bus and helper tasks
   task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      b_addr <= a;
      b_wdata <= d;
      b_wr <= 1'b1;
      @(posedge clk);
      b_wr <= 1'b0;
   endtask

   task automatic bus_rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      b_addr <= a;
      b_rd <= 1'b1;
      @(posedge clk);
      b_rd <= 1'b0;
      #1 d = rdata;
   endtask

   function automatic logic [15:0] exp_rd(input logic [4:0] s, input logic [15:0] c);
      if (s == 5'h0C || s == 5'h11 || s > 5'h12) return 16'h0000;
      if (s == 5'h12) return c;
      return {8'h5A, 1'b0, s, 2'b00};
   endfunction

   task automatic start_burst(input logic wmode, input logic smode);
      dma_wr <= wmode;
      slow <= smode;
      @(posedge clk);
      ev <= 1'b1;
      @(posedge clk);
      ev <= 1'b0;
      dma_en <= 1'b1;
      #1 `CHK(busy, 1'b1)
   endtask

   task automatic end_burst();
      for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge clk);
      repeat (3) @(posedge clk);
      `CHK(busy, 1'b0)
      `CHK(dma_req, 1'b0)
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset();
      logic [15:0] d;
      bus_rd(OFF_CONTROL, d);
      `CHK(d, CONTROL_RESET)
      bus_rd(OFF_WINDOW, d);
      `CHK(d, 16'h5A00)
      bus_wr(8'h44, 16'h1F1F);
      bus_rd(8'h50, d);
      `CHK(d, 16'h0000)
      bus_rd(OFF_CONTROL, d);
      `CHK(d, CONTROL_RESET)
      bus_wr(OFF_CONTROL, 16'hFFFF);
      bus_rd(OFF_CONTROL, d);
      `CHK(d, 16'h1F1F)
   endtask

   task automatic run_read(input logic [4:0] len, input logic [4:0] base, input logic sm);
      logic [15:0] c;
      c = {3'b000, len, 3'b000, base};
      bus_wr(OFF_CONTROL, c);
      start_burst(1'b0, sm);
      end_burst();
      `CHK(p_count, {1'b0, len} + 6'h01)
      for (int i = 0; i <= len; i++) `CHK(dma_partner_i.mem[i], exp_rd(base + 5'(i), c))
      @(posedge clk);
      dma_en <= 1'b0;
   endtask

   task automatic t_write_stall();
      drained.delete();
      bus_wr(OFF_CONTROL, 16'h0501);
      wready <= 1'b0;
      start_burst(1'b1, 1'b0);
      repeat (20) @(posedge clk);
      #1 `CHK(dma_req, 1'b0)
      `CHK(busy, 1'b1)
      `CHK(p_count, 6'h04)
      `CHK(slot_wvalid, 1'b1)
      @(posedge clk);
      wready <= 1'b1;
      end_burst();
      `CHK(p_count, 6'h06)
      @(posedge clk);
      dma_en <= 1'b0;
      `CHK(drained.size(), 6)
      for (int i = 0; i < 6; i++) `CHK(drained[i], {8'((i + 1) * 4), 16'hD000 | 16'(i)})
   endtask

   task automatic t_write_control();
      logic [15:0] d;
      drained.delete();
      bus_wr(OFF_CONTROL, 16'h0012);
      start_burst(1'b1, 1'b0);
      end_burst();
      @(posedge clk);
      dma_en <= 1'b0;
      repeat (4) @(posedge clk);
      bus_rd(OFF_CONTROL, d);
      `CHK(d, 16'h1000)
      `CHK(drained.size(), 0)
   endtask

   // ==========================================================
   // Verdict, watchdog and main sequence
   task automatic test_done();
      if (fail_count == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      #500000;
      fail_count++;
      test_done();
   end

   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      run_read(5'h03, 5'h0D, 1'b0);
      // Same burst again must restart at the base slot
      run_read(5'h03, 5'h0D, 1'b1);
      run_read(5'h11, 5'h00, 1'b0);
      run_read(5'h00, 5'h12, 1'b1);
      t_write_stall();
      t_write_control();
      test_done();
   end
endmodule
`default_nettype wire
